// ===== logic/csf_map.vh
// address map, field positions, reset values and opcodes of the special function registers
`ifndef CSF_MAP_VH
`define CSF_MAP_VH

// address layout: upper nibble selects the sector, low byte the location
`define CSF_AW 12
`define CSF_SEC_W 4
`define CSF_RAM_AW 9
`define CSF_RAM_DEPTH 512
`define CSF_SECTOR0 4'h0

// special function locations, mirrored at the bottom of every sector
`define CSF_SFR_TOP 8'h10
`define CSF_A_IND_NEAR 8'h00
`define CSF_A_NEAR_PTR 8'h01
`define CSF_A_IND_ONE 8'h02
`define CSF_A_ONE_LOW 8'h03
`define CSF_A_ONE_SEC 8'h04
`define CSF_A_PCL 8'h06
`define CSF_A_TBL_LOW 8'h07
`define CSF_A_TBL_DATA 8'h08
`define CSF_A_TBL_HIGH 8'h09
`define CSF_A_STATUS 8'h0a
`define CSF_A_BANK 8'h0b
`define CSF_A_IND_TWO 8'h0c
`define CSF_A_TWO_LOW 8'h0d
`define CSF_A_TWO_SEC 8'h0e

// status register fields
`define CSF_ST_C 0
`define CSF_ST_AC 1
`define CSF_ST_Z 2
`define CSF_ST_OV 3
`define CSF_ST_PDF 4
`define CSF_ST_TO 5
`define CSF_ST_CZ 6
`define CSF_ST_SC 7
`define CSF_STATUS_WMASK 8'h0f
`define CSF_STATUS_RST 8'h00

// reset values
`define CSF_BYTE_RST 8'h00
`define CSF_BANK_RST 1'b0
`define CSF_BANK_PAD 7'h00
`define CSF_READ_ZERO 8'h00

// flag unit operations
`define CSF_OP_W 4
`define CSF_OP_ADD 4'h0
`define CSF_OP_ADC 4'h1
`define CSF_OP_SUB 4'h2
`define CSF_OP_SBC 4'h3
`define CSF_OP_AND 4'h4
`define CSF_OP_OR 4'h5
`define CSF_OP_XOR 4'h6
`define CSF_OP_RLC 4'h7
`define CSF_OP_RRC 4'h8

`endif

// ===== logic/csf_data_ram.v
// flip-flop data memory, one write port and one combinational read port
`timescale 1ns/1ns
`default_nettype none
`include "csf_map.vh"

module csf_data_ram (
  input wire clk,
  input wire we,
  input wire [`CSF_RAM_AW-1:0] wrIdx,
  input wire [7:0] wrData,
  input wire [`CSF_RAM_AW-1:0] rdIdx,
  output wire [7:0] rdData
);
  // contents are undefined after reset, as with ordinary data memory
  reg [7:0] mem [0:`CSF_RAM_DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[wrIdx] <= wrData;
    end
  end

  assign rdData = mem[rdIdx];

endmodule
`default_nettype wire

// ===== logic/csf_flag_unit.v
// arithmetic and logic result with the status flags it produces
`timescale 1ns/1ns
`default_nettype none
`include "csf_map.vh"

module csf_flag_unit (
  input wire [`CSF_OP_W-1:0] op,
  input wire [7:0] opA,
  input wire [7:0] opB,
  input wire carryIn,
  input wire ovIn,
  input wire czIn,
  output reg [7:0] result,
  output reg carryOut,
  output reg nibbleOut,
  output reg zeroOut,
  output reg ovOut,
  output reg scOut,
  output reg czOut,
  output reg updCarry,
  output reg updArith,
  output reg updZero,
  output reg updCz
);
  reg isSub;
  reg cin;
  reg [7:0] bOp;
  reg [8:0] sum;
  reg [4:0] lowSum;
  reg [7:0] lowSeven;

  always @* begin
    isSub = (op == `CSF_OP_SUB) || (op == `CSF_OP_SBC);
    bOp = isSub ? ~opB : opB;
    case (op)
      `CSF_OP_ADC, `CSF_OP_SBC: cin = carryIn;
      `CSF_OP_SUB: cin = 1'b1;
      default: cin = 1'b0;
    endcase
    sum = {1'b0, opA} + {1'b0, bOp} + {8'h00, cin};
    lowSum = {1'b0, opA[3:0]} + {1'b0, bOp[3:0]} + {4'h0, cin};
    lowSeven = {1'b0, opA[6:0]} + {1'b0, bOp[6:0]} + {7'h00, cin};
    result = sum[7:0];
    carryOut = sum[8]; // RULE14
    nibbleOut = lowSum[4]; // RULE15
    ovOut = lowSeven[7] ^ sum[8]; // RULE17
    updCarry = 1'b1;
    updArith = 1'b1;
    updZero = 1'b1;
    updCz = isSub;
    case (op)
      `CSF_OP_AND: result = opA & opB;
      `CSF_OP_OR: result = opA | opB;
      `CSF_OP_XOR: result = opA ^ opB;
      `CSF_OP_RLC: begin
        result = {opA[6:0], carryIn};
        carryOut = opA[7]; // RULE14
      end
      `CSF_OP_RRC: begin
        result = {carryIn, opA[7:1]};
        carryOut = opA[0]; // RULE14
      end
      default: result = sum[7:0];
    endcase
    if (op == `CSF_OP_AND || op == `CSF_OP_OR || op == `CSF_OP_XOR) begin
      updCarry = 1'b0;
      updArith = 1'b0;
    end
    if (op == `CSF_OP_RLC || op == `CSF_OP_RRC) begin
      updArith = 1'b0;
      updZero = 1'b0;
    end
    zeroOut = (result == 8'h00); // RULE16
    // the comparison sign uses the overflow that this operation leaves behind
    scOut = (updArith ? ovOut : ovIn) ^ result[7]; // RULE20
    // plain subtract copies zero, subtract with borrow chains it
    czOut = (op == `CSF_OP_SBC) ? (czIn & zeroOut) : zeroOut;
  end

endmodule
`default_nettype wire

// ===== logic/csf_sfr.v
// special function registers: pointers, bank select, pc low, table, status
`timescale 1ns/1ns
`default_nettype none
`include "csf_map.vh"

// Behaviour
// RULE1: indirect port access goes to the data location held in its paired pointer.
// RULE2: pointers are data-memory locations, read and written like ordinary registers.
// RULE3: near indirect port reaches sector 0 only, whatever the pointer holds.
// RULE4: far ports take sector from the sector byte, location from the low byte.
// RULE5: extended direct address: upper part picks sector, low byte the location.
// RULE6: bank bit clear selects program bank 0, set selects bank 1.
// RULE7: bank register bits 7..1 read zero; bank bit resets to zero.
// RULE8: software sets the bank before a jump or call.
// RULE9: writing pc low jumps within the current program page.
// RULE10: a pc low jump adds one dummy instruction cycle.
// RULE11: table read fetches word at table pointers, high byte latched, low stored.
// RULE12: no register-to-register move; data always passes through the accumulator.
// RULE13: status writes never change watchdog expired or sleep entered flags.
// RULE14: carry set on add carry or subtract without borrow; rotates update it.
// RULE15: nibble carry set on low-nibble carry or no nibble borrow.
// RULE16: zero flag set when the result is zero.
// RULE17: overflow set when carry into msb differs from carry out.
// RULE18: sleep entered cleared by reset or watchdog clear, set by halt.
// RULE19: watchdog expired cleared by reset, clear or halt; set on timeout.
// RULE20: signed compare flag is overflow xor result msb.
// RULE21: status is never saved automatically on interrupt or call.
// RULE22: status bits 0..3 are readable and writable.
// RULE23: indirect ports hold nothing; direct reads give zero, writes do nothing. Here that holds only for a port reached through a pointer.
// RULE24: low pointer bytes wrap modulo 256, leaving the sector byte alone.
module csf_sfr (
  input wire clk,
  input wire rst,
  input wire cpuRd,
  input wire cpuWr,
  input wire cpuExt,
  input wire [`CSF_AW-1:0] cpuAddr,
  input wire [7:0] cpuWrData,
  input wire [7:0] pcLowIn,
  input wire aluValid,
  input wire [`CSF_OP_W-1:0] aluOp,
  input wire [7:0] aluA,
  input wire [7:0] aluB,
  input wire tblRead,
  input wire [`CSF_AW-1:0] tblDest,
  input wire [15:0] progData,
  input wire progValid,
  input wire wdtClear,
  input wire haltExec,
  input wire wdtTimeout,
  output reg [7:0] rdData_r,
  output reg rdValid_r,
  output reg [7:0] aluResult_r,
  output reg [7:0] status_r,
  output reg progBank_r,
  output reg pcJump_r,
  output reg [7:0] pcJumpLow_r,
  output reg dummyCycle_r,
  output reg [15:0] progAddr_r,
  output reg progReq_r,
  output reg tblBusy_r
);
  localparam [1:0] T_IDLE = 2'b00;
  localparam [1:0] T_FETCH = 2'b01;
  localparam [1:0] T_WRITE = 2'b10;

  reg [7:0] nearPtr_r;
  reg [7:0] farOneLow_r;
  reg [7:0] farOneSec_r;
  reg [7:0] farTwoLow_r;
  reg [7:0] farTwoSec_r;
  reg [7:0] tblLow_r;
  reg [7:0] tblHigh_r;
  reg [7:0] tblData_r;
  reg [7:0] tblLowByte_r;
  reg [`CSF_AW-1:0] tblDest_r;
  reg [1:0] tState_r;
  reg [1:0] tState_nxt;

  // an indirect port stands for its pointer's target
  function [`CSF_AW-1:0] resolve;
    input [`CSF_AW-1:0] a;
    begin
      case (a[7:0])
        `CSF_A_IND_NEAR: resolve = {`CSF_SECTOR0, nearPtr_r}; // RULE1 RULE3
        `CSF_A_IND_ONE: resolve = {farOneSec_r[`CSF_SEC_W-1:0], farOneLow_r}; // RULE1 RULE4
        `CSF_A_IND_TWO: resolve = {farTwoSec_r[`CSF_SEC_W-1:0], farTwoLow_r}; // RULE1 RULE4
        default: resolve = a;
      endcase
    end
  endfunction

  function isIndirect;
    input [7:0] lo;
    begin
      isIndirect = (lo == `CSF_A_IND_NEAR) || (lo == `CSF_A_IND_ONE) ||
        (lo == `CSF_A_IND_TWO);
    end
  endfunction

  // plain direct addressing stays in sector 0; extended addressing carries the sector
  wire [`CSF_AW-1:0] cpuEff = cpuExt ? cpuAddr : {`CSF_SECTOR0, cpuAddr[7:0]}; // RULE5
  wire [`CSF_AW-1:0] cpuRes = resolve(cpuEff);
  wire [`CSF_AW-1:0] tblRes = resolve(tblDest_r);
  wire tblWrite = (tState_r == T_WRITE);

  // the table store owns the write port for one cycle; the cpu waits on tblBusy_r
  wire wrEn = tblWrite | cpuWr;
  wire [`CSF_AW-1:0] wrAddr = tblWrite ? tblRes : cpuRes;
  wire [7:0] wrData = tblWrite ? tblLowByte_r : cpuWrData; // RULE12
  wire wrSfr = (wrAddr[7:0] < `CSF_SFR_TOP);
  wire rdSfr = (cpuRes[7:0] < `CSF_SFR_TOP);
  // only the low sector bit exists in this memory; higher sectors alias onto it
  wire ramWe = wrEn & ~wrSfr;
  wire [7:0] ramRdData;

  csf_data_ram uRam (
    .clk(clk),
    .we(ramWe),
    .wrIdx(wrAddr[`CSF_RAM_AW-1:0]),
    .wrData(wrData),
    .rdIdx(cpuRes[`CSF_RAM_AW-1:0]),
    .rdData(ramRdData)
  );

  wire [7:0] fuResult;
  wire fuC;
  wire fuAc;
  wire fuZ;
  wire fuOv;
  wire fuSc;
  wire fuCz;
  wire updC;
  wire updArith;
  wire updZ;
  wire updCz;

  csf_flag_unit uFlags (
    .op(aluOp),
    .opA(aluA),
    .opB(aluB),
    .carryIn(status_r[`CSF_ST_C]),
    .ovIn(status_r[`CSF_ST_OV]),
    .czIn(status_r[`CSF_ST_CZ]),
    .result(fuResult),
    .carryOut(fuC),
    .nibbleOut(fuAc),
    .zeroOut(fuZ),
    .ovOut(fuOv),
    .scOut(fuSc),
    .czOut(fuCz),
    .updCarry(updC),
    .updArith(updArith),
    .updZero(updZ),
    .updCz(updCz)
  );

  // special function register writes, flag updates and system flag events
  always @(posedge clk) begin
    if (rst) begin
      nearPtr_r <= `CSF_BYTE_RST;
      farOneLow_r <= `CSF_BYTE_RST;
      farOneSec_r <= `CSF_BYTE_RST;
      farTwoLow_r <= `CSF_BYTE_RST;
      farTwoSec_r <= `CSF_BYTE_RST;
      tblLow_r <= `CSF_BYTE_RST;
      tblHigh_r <= `CSF_BYTE_RST;
      progBank_r <= `CSF_BANK_RST; // RULE7
      status_r <= `CSF_STATUS_RST; // RULE18 RULE19
      pcJump_r <= 1'b0;
      pcJumpLow_r <= `CSF_BYTE_RST;
      aluResult_r <= `CSF_BYTE_RST;
    end else begin
      pcJump_r <= 1'b0;
      // an indirect port reached through a pointer stores nothing
      if (wrEn && wrSfr && !isIndirect(wrAddr[7:0])) begin // RULE23
        case (wrAddr[7:0])
          // pointers are plain bytes, so inc/dec wraps without carry into the sector
          `CSF_A_NEAR_PTR: nearPtr_r <= wrData; // RULE2 RULE24
          `CSF_A_ONE_LOW: farOneLow_r <= wrData; // RULE2 RULE24
          `CSF_A_ONE_SEC: farOneSec_r <= wrData; // RULE2
          `CSF_A_TWO_LOW: farTwoLow_r <= wrData; // RULE2 RULE24
          `CSF_A_TWO_SEC: farTwoSec_r <= wrData; // RULE2
          `CSF_A_TBL_LOW: tblLow_r <= wrData;
          `CSF_A_TBL_HIGH: tblHigh_r <= wrData;
          `CSF_A_BANK: progBank_r <= wrData[0]; // RULE6
          `CSF_A_PCL: begin
            pcJump_r <= 1'b1; // RULE9
            pcJumpLow_r <= wrData; // RULE9
          end
          `CSF_A_STATUS: begin
            status_r[3:0] <= wrData[3:0]; // RULE22 RULE13
          end
          default: ;
        endcase
      end
      // a flag result in the same cycle as a status write overrides the written bit
      if (aluValid) begin
        aluResult_r <= fuResult;
        if (updC) begin
          status_r[`CSF_ST_C] <= fuC; // RULE14
        end
        if (updArith) begin
          status_r[`CSF_ST_AC] <= fuAc; // RULE15
          status_r[`CSF_ST_OV] <= fuOv; // RULE17
          status_r[`CSF_ST_SC] <= fuSc; // RULE20
        end
        if (updZ) begin
          status_r[`CSF_ST_Z] <= fuZ; // RULE16
        end
        if (updCz) begin
          status_r[`CSF_ST_CZ] <= fuCz;
        end
      end
      // set wins over clear when both arrive together
      if (haltExec) begin
        status_r[`CSF_ST_PDF] <= 1'b1; // RULE18
      end else if (wdtClear) begin
        status_r[`CSF_ST_PDF] <= 1'b0; // RULE18
      end
      if (wdtTimeout) begin
        status_r[`CSF_ST_TO] <= 1'b1; // RULE19
      end else if (wdtClear || haltExec) begin
        status_r[`CSF_ST_TO] <= 1'b0; // RULE19
      end
    end
  end

  // the pc low jump costs one extra cycle behind the jump strobe
  always @(posedge clk) begin
    if (rst) begin
      dummyCycle_r <= 1'b0;
    end else begin
      dummyCycle_r <= pcJump_r; // RULE10
    end
  end

  // read port: one cycle from the request to the data
  always @(posedge clk) begin
    if (rst) begin
      rdData_r <= `CSF_BYTE_RST;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= cpuRd;
      if (cpuRd) begin
        if (isIndirect(cpuRes[7:0])) begin
          rdData_r <= `CSF_READ_ZERO; // RULE23
        end else if (rdSfr) begin
          case (cpuRes[7:0])
            `CSF_A_NEAR_PTR: rdData_r <= nearPtr_r; // RULE2
            `CSF_A_ONE_LOW: rdData_r <= farOneLow_r; // RULE2
            `CSF_A_ONE_SEC: rdData_r <= farOneSec_r; // RULE2
            `CSF_A_TWO_LOW: rdData_r <= farTwoLow_r; // RULE2
            `CSF_A_TWO_SEC: rdData_r <= farTwoSec_r; // RULE2
            `CSF_A_PCL: rdData_r <= pcLowIn;
            `CSF_A_TBL_LOW: rdData_r <= tblLow_r;
            `CSF_A_TBL_HIGH: rdData_r <= tblHigh_r;
            `CSF_A_TBL_DATA: rdData_r <= tblData_r;
            `CSF_A_STATUS: rdData_r <= status_r;
            `CSF_A_BANK: rdData_r <= {`CSF_BANK_PAD, progBank_r}; // RULE7
            default: rdData_r <= `CSF_READ_ZERO;
          endcase
        end else begin
          rdData_r <= ramRdData;
        end
      end
    end
  end

  // table read sequencer
  always @* begin
    tState_nxt = tState_r;
    case (tState_r)
      T_IDLE: begin
        if (tblRead) begin
          tState_nxt = T_FETCH;
        end
      end
      T_FETCH: begin
        if (progValid) begin
          tState_nxt = T_WRITE;
        end
      end
      T_WRITE: tState_nxt = T_IDLE;
      default: tState_nxt = T_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      tState_r <= T_IDLE;
      progAddr_r <= {`CSF_BYTE_RST, `CSF_BYTE_RST};
      progReq_r <= 1'b0;
      tblBusy_r <= 1'b0;
      tblData_r <= `CSF_BYTE_RST;
      tblLowByte_r <= `CSF_BYTE_RST;
      tblDest_r <= {`CSF_SECTOR0, `CSF_BYTE_RST};
    end else begin
      tState_r <= tState_nxt;
      case (tState_r)
        T_IDLE: begin
          if (tblRead) begin
            progAddr_r <= {tblHigh_r, tblLow_r}; // RULE11
            progReq_r <= 1'b1;
            tblBusy_r <= 1'b1;
            tblDest_r <= tblDest;
          end
        end
        T_FETCH: begin
          if (progValid) begin
            tblData_r <= progData[15:8]; // RULE11
            tblLowByte_r <= progData[7:0]; // RULE11
            progReq_r <= 1'b0;
          end
        end
        T_WRITE: tblBusy_r <= 1'b0;
        default: begin
          progReq_r <= 1'b0;
          tblBusy_r <= 1'b0;
        end
      endcase
    end
  end

  // status is only ever an ordinary register here; nothing pushes it on entry
  // to an interrupt or call, so software saves it when it matters (RULE21).
  // moves between two data locations are two accesses through the accumulator,
  // since this port offers one transfer per cycle with cpu-side or table-fetch data only (RULE12).

endmodule
`default_nettype wire

// ===== sim/csf_sfr_checker.sv
// concurrent checks on the special function register block ports
`timescale 1ns/1ns
`default_nettype none
`include "csf_map.vh"
module csf_sfr_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic cpuRd,
  input wire logic cpuWr,
  input wire logic [`CSF_AW-1:0] cpuAddr,
  input wire logic [7:0] cpuWrData,
  input wire logic aluValid,
  input wire logic [`CSF_OP_W-1:0] aluOp,
  input wire logic tblRead,
  input wire logic progValid,
  input wire logic wdtClear,
  input wire logic haltExec,
  input wire logic wdtTimeout,
  input wire logic [7:0] rdData_r,
  input wire logic rdValid_r,
  input wire logic [7:0] aluResult_r,
  input wire logic [7:0] status_r,
  input wire logic progBank_r,
  input wire logic pcJump_r,
  input wire logic [7:0] pcJumpLow_r,
  input wire logic dummyCycle_r,
  input wire logic progReq_r,
  input wire logic tblBusy_r
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rd_valid;
    cpuRd |=> rdValid_r;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
  property p_bank_read;
    cpuRd && cpuAddr[7:0] == `CSF_A_BANK |=> rdData_r == {7'h00, $past(progBank_r)};
  endproperty
  a_bank_read: assert property (p_bank_read) else $error("bank read wrong");
  property p_pcl_jump;
    cpuWr && !tblBusy_r && cpuAddr[7:0] == `CSF_A_PCL
      |=> pcJump_r && pcJumpLow_r == $past(cpuWrData);
  endproperty
  a_pcl_jump: assert property (p_pcl_jump) else $error("pc low jump missing");
  property p_dummy;
    pcJump_r |=> dummyCycle_r;
  endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy cycle");
  // system flag events excluded so only the software write path is judged
  property p_status_wr;
    cpuWr && !tblBusy_r && cpuAddr[7:0] == `CSF_A_STATUS && !aluValid
      && !wdtClear && !haltExec && !wdtTimeout
      |=> $stable(status_r[5:4]) && status_r[3:0] == $past(cpuWrData[3:0]);
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status write wrong");
  property p_to_set;
    wdtTimeout |=> status_r[`CSF_ST_TO];
  endproperty
  a_to_set: assert property (p_to_set) else $error("timeout flag not set");
  property p_pdf_set;
    haltExec |=> status_r[`CSF_ST_PDF] && (!status_r[`CSF_ST_TO] || $past(wdtTimeout));
  endproperty
  a_pdf_set: assert property (p_pdf_set) else $error("halt flags wrong");
  property p_sys_clear;
    wdtClear && !haltExec && !wdtTimeout |=> status_r[5:4] == 2'b00;
  endproperty
  a_sys_clear: assert property (p_sys_clear) else $error("clear left flags");
  property p_sc;
    aluValid && aluOp <= `CSF_OP_SBC
      |=> status_r[`CSF_ST_SC] == (status_r[`CSF_ST_OV] ^ aluResult_r[7]);
  endproperty
  a_sc: assert property (p_sc) else $error("signed compare wrong");
  property p_zero;
    aluValid && aluOp < `CSF_OP_RLC |=> status_r[`CSF_ST_Z] == (aluResult_r == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_tbl_start;
    tblRead && !tblBusy_r |=> progReq_r && tblBusy_r;
  endproperty
  a_tbl_start: assert property (p_tbl_start) else $error("table read not started");
  property p_tbl_hold;
    progReq_r && !progValid |=> progReq_r;
  endproperty
  a_tbl_hold: assert property (p_tbl_hold) else $error("fetch request dropped");
endmodule
bind csf_sfr csf_sfr_checker u_chk (.clk(clk), .rst(rst), .cpuRd(cpuRd), .cpuWr(cpuWr),
  .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .aluValid(aluValid), .aluOp(aluOp),
  .tblRead(tblRead), .progValid(progValid), .wdtClear(wdtClear), .haltExec(haltExec),
  .wdtTimeout(wdtTimeout), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
  .aluResult_r(aluResult_r), .status_r(status_r), .progBank_r(progBank_r),
  .pcJump_r(pcJump_r), .pcJumpLow_r(pcJumpLow_r), .dummyCycle_r(dummyCycle_r),
  .progReq_r(progReq_r), .tblBusy_r(tblBusy_r));
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the special function register block
`timescale 1ns/1ns
`default_nettype none
`include "csf_map.vh"
module tb;
  logic clk, rst, cpuRd, cpuWr, cpuExt, aluValid, tblRead, progValid;
  logic wdtClear, haltExec, wdtTimeout;
  logic [`CSF_AW-1:0] cpuAddr, tblDest;
  logic [7:0] cpuWrData, pcLowIn, aluA, aluB;
  logic [`CSF_OP_W-1:0] aluOp;
  logic [15:0] progData;
  wire [7:0] rdData_r, aluResult_r, status_r, pcJumpLow_r;
  wire rdValid_r, progBank_r, pcJump_r, dummyCycle_r, progReq_r, tblBusy_r;
  wire [15:0] progAddr_r;
  integer miscompares = 0;
  integer checks = 0;
  integer n;
  csf_sfr dut (.clk(clk), .rst(rst), .cpuRd(cpuRd), .cpuWr(cpuWr), .cpuExt(cpuExt),
    .cpuAddr(cpuAddr), .cpuWrData(cpuWrData), .pcLowIn(pcLowIn), .aluValid(aluValid),
    .aluOp(aluOp), .aluA(aluA), .aluB(aluB), .tblRead(tblRead), .tblDest(tblDest),
    .progData(progData), .progValid(progValid), .wdtClear(wdtClear), .haltExec(haltExec),
    .wdtTimeout(wdtTimeout), .rdData_r(rdData_r), .rdValid_r(rdValid_r),
    .aluResult_r(aluResult_r), .status_r(status_r), .progBank_r(progBank_r),
    .pcJump_r(pcJump_r), .pcJumpLow_r(pcJumpLow_r), .dummyCycle_r(dummyCycle_r),
    .progAddr_r(progAddr_r), .progReq_r(progReq_r), .tblBusy_r(tblBusy_r));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    cpuWr = 1'b1;
    cpuAddr = a;
    cpuWrData = d;
    @(negedge clk);
    cpuWr = 1'b0;
  endtask
  // read answer lands one cycle after the request edge
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk);
    cpuRd = 1'b1;
    cpuAddr = a;
    @(negedge clk);
    cpuRd = 1'b0;
    chk({7'h00, rdValid_r, rdData_r}, {8'h01, e});
  endtask
  task automatic sys(input logic [2:0] v, input logic [1:0] e);
    @(negedge clk);
    {wdtClear, haltExec, wdtTimeout} = v;
    @(negedge clk);
    {wdtClear, haltExec, wdtTimeout} = 3'b000;
    chk(status_r[5:4], e);
  endtask
  task automatic alu(input logic [3:0] op, input logic [3:0] pre, input logic [7:0] a,
    input logic [7:0] b, input logic [7:0] res, input logic [3:0] st, input logic sc);
    wr(12'h00a, {4'h0, pre});
    aluValid = 1'b1;
    aluOp = op;
    aluA = a;
    aluB = b;
    @(negedge clk);
    aluValid = 1'b0;
    chk(aluResult_r, res);
    chk(status_r[3:0], st);
    if (op <= `CSF_OP_SBC) chk(status_r[7], sc);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    {rst, cpuRd, cpuWr, aluValid, tblRead, progValid} = 6'h20;
    {wdtClear, haltExec, wdtTimeout} = 3'b000;
    {cpuExt, cpuAddr, tblDest, cpuWrData, pcLowIn} = {1'b1, 12'h000, 12'h050, 16'h0034};
    {aluOp, aluA, aluB, progData} = 36'h0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk(status_r, 8'h00);
    chk(progBank_r, 1'b0);
    rd(12'h00b, 8'h00);
    $display("test reset done");
    wr(12'h00b, 8'hff);
    rd(12'h00b, 8'h01);
    chk(progBank_r, 1'b1);
    wr(12'h00b, 8'hfe);
    chk(progBank_r, 1'b0);
    $display("test bank done");
    wr(12'h140, 8'ha5);
    wr(12'h001, 8'h40);
    rd(12'h001, 8'h40);
    wr(12'h100, 8'h3c);
    rd(12'h140, 8'ha5);
    rd(12'h040, 8'h3c);
    cpuExt = 1'b0;
    rd(12'h140, 8'h3c);
    cpuExt = 1'b1;
    wr(12'h004, 8'h01);
    wr(12'h003, 8'h80);
    wr(12'h002, 8'h77);
    rd(12'h180, 8'h77);
    rd(12'h002, 8'h77);
    rd(12'h004, 8'h01);
    wr(12'h003, 8'hff);
    wr(12'h002, 8'h99);
    rd(12'h1ff, 8'h99);
    rd(12'h004, 8'h01);
    wr(12'h00e, 8'h00);
    wr(12'h00d, 8'h80);
    wr(12'h00c, 8'h5e);
    rd(12'h080, 8'h5e);
    wr(12'h00d, 8'h0c);
    rd(12'h00c, 8'h00);
    $display("test pointers done");
    wr(12'h00b, 8'h01);
    wr(12'h006, 8'h12);
    chk({pcJump_r, pcJumpLow_r}, 9'h112);
    @(negedge clk);
    chk({pcJump_r, dummyCycle_r}, 2'b01);
    rd(12'h006, 8'h34);
    $display("test pc low done");
    wr(12'h00a, 8'hff);
    rd(12'h00a, 8'h0f);
    sys(3'b010, 2'b01);
    sys(3'b001, 2'b11);
    wr(12'h00a, 8'h00);
    rd(12'h00a, 8'h30);
    sys(3'b100, 2'b00);
    sys(3'b001, 2'b10);
    sys(3'b010, 2'b01);
    $display("test status done");
    alu(4'h0, 4'h0, 8'h7f, 8'h01, 8'h80, 4'ha, 1'b0);
    alu(4'h0, 4'h0, 8'hff, 8'h01, 8'h00, 4'h7, 1'b0);
    alu(4'h1, 4'h1, 8'h10, 8'h20, 8'h31, 4'h0, 1'b0);
    alu(4'h2, 4'h0, 8'h05, 8'h06, 8'hff, 4'h0, 1'b1);
    alu(4'h2, 4'h0, 8'h80, 8'h01, 8'h7f, 4'h9, 1'b1);
    alu(4'h3, 4'h0, 8'h10, 8'h0f, 8'h00, 4'h5, 1'b0);
    rd(12'h00a, 8'h15);
    alu(4'h2, 4'h0, 8'h33, 8'h33, 8'h00, 4'h7, 1'b0);
    rd(12'h00a, 8'h57);
    alu(4'h4, 4'hb, 8'hf0, 8'h0f, 8'h00, 4'hf, 1'b0);
    alu(4'h5, 4'h0, 8'h00, 8'h00, 8'h00, 4'h4, 1'b0);
    alu(4'h6, 4'h4, 8'h5a, 8'h0f, 8'h55, 4'h0, 1'b0);
    alu(4'h7, 4'h4, 8'h81, 8'h00, 8'h02, 4'h5, 1'b0);
    alu(4'h8, 4'h9, 8'h01, 8'h00, 8'h80, 4'h9, 1'b0);
    $display("test flags done");
    wr(12'h007, 8'h34);
    wr(12'h009, 8'h12);
    @(negedge clk);
    tblRead = 1'b1;
    @(negedge clk);
    tblRead = 1'b0;
    chk(progAddr_r, 16'h1234);
    chk({progReq_r, tblBusy_r}, 2'b11);
    @(negedge clk);
    chk(progReq_r, 1'b1);
    progData = 16'hbeef;
    progValid = 1'b1;
    @(negedge clk);
    progValid = 1'b0;
    progData = 16'h4110;
    n = 0;
    while (tblBusy_r !== 1'b0 && n < 20) begin
      @(negedge clk);
      n = n + 1;
    end
    chk(tblBusy_r, 1'b0);
    rd(12'h008, 8'hbe);
    rd(12'h050, 8'hef);
    $display("test table done");
    finish_test;
  end
endmodule
`default_nettype wire
